// File: rtl/pll_ctrl_pkg.sv
// shared types and constants for the loop control block
package pll_ctrl_pkg;
   // reset values
   localparam logic OSC_DIV_RST  = 1'b0;
   localparam logic OSC_OUT_RST  = 1'b0;
   localparam logic PUMP_RST     = 1'b0;
   // synchroniser depth in flip-flops
   localparam int   SYNC_STAGES  = 2;

   typedef struct packed {
      logic osc_power_down;
      logic detector_power_down;
      logic div_select;
   } ctrl_t;

   typedef struct packed {
      logic up;
      logic down;
   } pump_t;

   typedef struct packed {
      logic pump_o;
      logic pump_oe;
   } pump_pin_t;

   // pin levels as they enter and leave the synchroniser
   typedef struct packed {
      logic core_lvl;
      logic ref_lvl;
      logic fb_lvl;
      logic osc_off;
      logic det_off;
      logic half_sel;
   } pin_sync_t;
endpackage

// File: rtl/pll_phase_detector_ctrl.sv
// digital control of the oscillator divider, inhibits and phase-frequency detector
// Overview of operation
// R1: select high halves oscillator output frequency
// R2: oscillator inhibit stops it, output low
// R3: detector inhibit tri-states charge-pump output
// R4: detector inhibit halts phase comparison entirely
// R5: edge-triggered compare of reference and feedback
// R6: system feeds reference and divided feedback
// R7: half-frequency output preferred for low jitter
// R8: oscillator and detector inhibits act independently
// R9: source when reference leads, sink when lagging
`timescale 1ns/1ps
module pll_phase_detector_ctrl
(
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   input  wire logic                   osc_core_clk,
   input  wire logic                   div_select,
   input  wire logic                   osc_power_down,
   input  wire logic                   detector_power_down,
   input  wire logic                   ref_freq_in,
   input  wire logic                   feedback_freq_in,
   output logic                        osc_clk_out,
   output logic                        charge_pump_out,
   output logic                        charge_pump_oe,
   output logic                        pump_up,
   output logic                        pump_down
);
   // every pin input except mclk and reset_n, the core square wave and the divide select included, passes two flops
   pll_ctrl_pkg::pin_sync_t            pin_raw;
   pll_ctrl_pkg::pin_sync_t            pin_sync;
   logic                               ref_prev_r;
   logic                               ref_prev_nxt;
   logic                               fb_prev_r;
   logic                               fb_prev_nxt;
   logic                               core_prev_r;
   logic                               core_prev_nxt;
   logic                               div_r;
   logic                               div_nxt;
   logic                               osc_r;
   logic                               osc_nxt;
   pll_ctrl_pkg::pump_t                pump_r;
   pll_ctrl_pkg::pump_t                pump_nxt;
   pll_ctrl_pkg::ctrl_t                ctrl;
   pll_ctrl_pkg::pump_pin_t            pin_r;
   pll_ctrl_pkg::pump_pin_t            pin_nxt;
   logic                               ref_rise;
   logic                               fb_rise;
   logic                               core_rise;
   genvar                              gi;

   always_comb
   begin
      pin_raw.core_lvl = osc_core_clk;
      pin_raw.ref_lvl  = ref_freq_in;
      pin_raw.fb_lvl   = feedback_freq_in;
      pin_raw.osc_off  = osc_power_down;
      pin_raw.det_off  = detector_power_down;
      pin_raw.half_sel = div_select;
   end

   // one chain per pin bit; the core wave must stay below half of mclk or edges are lost
   generate
      for (gi = 0; gi < $bits(pll_ctrl_pkg::pin_sync_t); gi = gi + 1)
      begin : g_sync
         logic [pll_ctrl_pkg::SYNC_STAGES-1:0] chain_r;
         logic [pll_ctrl_pkg::SYNC_STAGES-1:0] chain_nxt;

         always_comb
         begin
            chain_nxt = {chain_r[pll_ctrl_pkg::SYNC_STAGES-2:0], pin_raw[gi]};
         end

         always_ff @(posedge mclk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               chain_r <= '0;
            end
            else
            begin
               chain_r <= chain_nxt;
            end
         end

         // only the last stage leaves the chain, the first may still be settling
         assign pin_sync[gi] = chain_r[pll_ctrl_pkg::SYNC_STAGES-1];
      end
   endgenerate

   always_comb
   begin
      ctrl.osc_power_down      = pin_sync.osc_off;
      ctrl.detector_power_down = pin_sync.det_off;
      ctrl.div_select          = pin_sync.half_sel;
      ref_rise      = pin_sync.ref_lvl & ~ref_prev_r;   // R5
      fb_rise       = pin_sync.fb_lvl & ~fb_prev_r;     // R5
      core_rise     = pin_sync.core_lvl & ~core_prev_r;
      ref_prev_nxt  = pin_sync.ref_lvl;
      fb_prev_nxt   = pin_sync.fb_lvl;
      core_prev_nxt = pin_sync.core_lvl;
   end

   // history resets to the idle low level, so no false edge follows reset
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ref_prev_r  <= 1'b0;
         fb_prev_r   <= 1'b0;
         core_prev_r <= 1'b0;
      end
      else
      begin
         ref_prev_r  <= ref_prev_nxt;
         fb_prev_r   <= fb_prev_nxt;
         core_prev_r <= core_prev_nxt;
      end
   end

   // oscillator path, independent of the detector state
   always_comb
   begin
      div_nxt = div_r;
      osc_nxt = osc_r;
      if (ctrl.osc_power_down)                // R2 R8
      begin
         div_nxt = pll_ctrl_pkg::OSC_DIV_RST;
         osc_nxt = 1'b0;                      // R2
      end
      else
      begin
         if (core_rise)
         begin
            div_nxt = ~div_r;                 // R1
         end
         // divided output toggles once per core cycle, full output follows core
         osc_nxt = ctrl.div_select ? div_r : pin_sync.core_lvl; // R1
      end
   end

   // divider restarts from its reset value each time the oscillator is released
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_r <= pll_ctrl_pkg::OSC_DIV_RST;
         osc_r <= pll_ctrl_pkg::OSC_OUT_RST;
      end
      else
      begin
         div_r <= div_nxt;
         osc_r <= osc_nxt;
      end
   end

   // detector: classic two-flop phase-frequency detector with reset on coincidence
   always_comb
   begin
      pump_nxt = pump_r;
      if (ctrl.detector_power_down)           // R4 R8
      begin
         pump_nxt = '0;                       // R4
      end
      else
      begin
         if (ref_rise)
         begin
            pump_nxt.up = 1'b1;               // R9
         end
         if (fb_rise)
         begin
            pump_nxt.down = 1'b1;             // R9
         end
         // both seen: clear, so matched edges leave the output undriven
         if (pump_nxt.up && pump_nxt.down)
         begin
            pump_nxt = '0;                    // R9
         end
      end
   end

   always_comb
   begin
      pin_nxt.pump_o  = pump_nxt.up;          // R9
      // driven only while one side leads and the detector is enabled
      pin_nxt.pump_oe = ~ctrl.detector_power_down & (pump_nxt.up ^ pump_nxt.down); // R3 R9
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pump_r.up   <= pll_ctrl_pkg::PUMP_RST;
         pump_r.down <= pll_ctrl_pkg::PUMP_RST;
      end
      else
      begin
         pump_r <= pump_nxt;
      end
   end

   // pin state taken from the same next value, so enable and level move with the pump state
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_r.pump_o  <= pll_ctrl_pkg::PUMP_RST;
         pin_r.pump_oe <= 1'b0;
      end
      else
      begin
         pin_r <= pin_nxt;
      end
   end

   always_comb
   begin
      osc_clk_out     = osc_r;
      charge_pump_out = pin_r.pump_o;
      charge_pump_oe  = pin_r.pump_oe;        // R3
      pump_up         = pump_r.up;
      pump_down       = pump_r.down;
   end
endmodule

// File: bench/pll_ctrl_chk.sv
// port checker for the loop control block
`timescale 1ns/1ps
module pll_ctrl_chk
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic osc_core_clk,
   input wire logic div_select,
   input wire logic osc_power_down,
   input wire logic detector_power_down,
   input wire logic ref_freq_in,
   input wire logic feedback_freq_in,
   input wire logic osc_clk_out,
   input wire logic charge_pump_out,
   input wire logic charge_pump_oe,
   input wire logic pump_up,
   input wire logic pump_down
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   osc_low_a: assert property (osc_power_down[*5] |-> !osc_clk_out) else $error("osc not low");
   pump_hiz_a: assert property (detector_power_down[*5] |-> !charge_pump_oe && !pump_up && !pump_down) else $error("pump on");
   up_dn_excl_a: assert property (!(pump_up && pump_down)) else $error("up and down");
   up_start_a: assert property ($rose(ref_freq_in) && !feedback_freq_in && !pump_down && !detector_power_down
      |-> ##[2:4] pump_up) else $error("no up");
   dn_start_a: assert property (!ref_freq_in[*4] ##0 ($rose(feedback_freq_in) && !pump_up && !detector_power_down)
      |-> ##[2:4] pump_down) else $error("no down");
   full_rate_a: assert property ((!osc_power_down && !div_select)[*5] |-> osc_clk_out == $past(osc_core_clk, 3))
      else $error("bad full rate");
   src_a: assert property ($rose(pump_up) |-> charge_pump_oe && charge_pump_out) else $error("no source");
   sink_a: assert property ($rose(pump_down) |-> charge_pump_oe && !charge_pump_out) else $error("no sink");
   cover property ($rose(pump_up));
   cover property ($rose(pump_down));
   cover property ($fell(osc_clk_out) && div_select);
endmodule
bind pll_phase_detector_ctrl pll_ctrl_chk chk
(
   .mclk                (mclk),
   .reset_n             (reset_n),
   .osc_core_clk        (osc_core_clk),
   .div_select          (div_select),
   .osc_power_down      (osc_power_down),
   .detector_power_down (detector_power_down),
   .ref_freq_in         (ref_freq_in),
   .feedback_freq_in    (feedback_freq_in),
   .osc_clk_out         (osc_clk_out),
   .charge_pump_out     (charge_pump_out),
   .charge_pump_oe      (charge_pump_oe),
   .pump_up             (pump_up),
   .pump_down           (pump_down)
);

// File: bench/fb_divider.sv
// feedback counter model: divides the oscillator output by four
`timescale 1ns/1ps
module fb_divider
(
   input  wire logic clk_in,
   input  wire logic reset_n,
   output logic      fb_out
);
   logic [1:0] cnt_r;
   // stands still while the oscillator is stopped, as a real counter would
   always_ff @(posedge clk_in or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_r <= 2'h0;
      end
      else
      begin
         cnt_r <= cnt_r + 2'h1;
      end
   end
   assign fb_out = cnt_r[1];
endmodule

// File: bench/tb_top.sv
// self-checking bench for the loop control block
`timescale 1ns/1ps
module tb_top;
   logic mclk = 0, reset_n = 0, osc_core_clk = 0, div_select = 0, osc_power_down = 0;
   logic detector_power_down = 0, ref_freq_in = 0;
   logic feedback_freq_in, osc_clk_out, charge_pump_out, charge_pump_oe, pump_up, pump_down;
   int n_errors = 0, check_count = 0, cyc = 0, n = 0, k;
   initial forever #50 mclk = !mclk;
   initial
   begin
      #37;
      forever #500 osc_core_clk = !osc_core_clk;
   end
   pll_phase_detector_ctrl dut
   (
      .mclk                (mclk),
      .reset_n             (reset_n),
      .osc_core_clk        (osc_core_clk),
      .div_select          (div_select),
      .osc_power_down      (osc_power_down),
      .detector_power_down (detector_power_down),
      .ref_freq_in         (ref_freq_in),
      .feedback_freq_in    (feedback_freq_in),
      .osc_clk_out         (osc_clk_out),
      .charge_pump_out     (charge_pump_out),
      .charge_pump_oe      (charge_pump_oe),
      .pump_up             (pump_up),
      .pump_down           (pump_down)
   );
   fb_divider fbm (.clk_in(osc_clk_out), .reset_n(reset_n), .fb_out(feedback_freq_in));
   always @(posedge osc_clk_out) n++;
   always @(posedge mclk) if (++cyc == 5000) begin n_errors++; stop_test; end
   task automatic step(int c); repeat (c) @(posedge mclk); #10; endtask
   task automatic chk(string nm, logic s, logic e);
      check_count++;
      if (s !== e) begin n_errors++; $display("[FAIL] %s exp %b got %b", nm, e, s); end
   endtask
   // edge counts over a window may be off by one from phase alone
   function automatic logic near(int got, int e); return got >= e - 1 && got <= e + 1; endfunction
   task automatic pulse; ref_freq_in = 1; step(2 + $urandom % 4); ref_freq_in = 0; step(2 + $urandom % 4); endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      void'($urandom(32'h8B3B3A8C));
      step(2); reset_n = 1; step(3);
      repeat (20) pulse;
      n = 0; step(200); chk("full rate", near(n, 20), 1);
      div_select = 1; n = 0; step(200); chk("half rate", near(n, 10), 1);
      detector_power_down = 1; step(6); chk("pump oe", charge_pump_oe, 0);
      pulse; chk("pump up", pump_up, 0);
      n = 0; step(100); chk("osc runs", n > 0, 1);
      detector_power_down = 0; osc_power_down = 1; step(8); n = 0; step(100);
      chk("osc low", osc_clk_out | (n > 0), 0);
      pulse; ref_freq_in = 1; step(5); chk("up osc off", pump_up, 1);
      chk("source", charge_pump_oe & charge_pump_out, 1);
      ref_freq_in = 0; osc_power_down = 0;
      for (k = 0; k < 400 && pump_down !== 1; k++) step(1);
      chk("down seen", pump_down, 1);
      step(1); chk("sink", charge_pump_oe & !charge_pump_out, 1);
      stop_test;
   end
endmodule
